// ---- hdl/cms_pkg.sv ----
// Constants, register map and types shared by the node supervision block.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package cms_pkg;
  localparam int NODES         = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] A_GUARD_EN  = 8'h00;
  localparam logic [7:0] A_POS       = 8'h04;
  localparam logic [7:0] A_MAP       = 8'h08;
  localparam logic [7:0] A_ERROR     = 8'h0c;
  localparam logic [7:0] A_STATUS    = 8'h10;
  localparam logic [2:0] A_NODE_PAGE = 3'h1;

  localparam int POS_CTRL    = 0;
  localparam int POS_LIVE    = 8;
  localparam int POS_EMCY    = 16;
  localparam int POS_ERR     = 24;
  localparam int MAP_CTRL_EN = 0;
  localparam int MAP_REQ_WIN = 8;
  localparam int MAP_RSP_WIN = 16;
  localparam int CFG_IVAL    = 0;
  localparam int CFG_LIMIT   = 16;

  localparam logic [7:0]  RST_GUARD_EN = 8'h00;
  localparam logic [31:0] RST_POS      = 32'h0a09_0200;
  localparam logic [31:0] RST_MAP      = 32'h0008_0800;
  localparam logic [31:0] RST_NODE_CFG = 32'h0003_03e8;

  localparam int CTL_EMCY = 7;
  localparam int CTL_OP   = 6;
  localparam int CTL_RTR  = 5;

  localparam int EMCY_DEPTH   = 10;
  localparam int EMCY_PTR_W   = 4;
  localparam int EMCY_W       = 67;
  localparam int EMCY_REC_LEN = 10;
  localparam int ERR_FAIL     = 0;
  localparam int ERR_OVERRUN  = 1;

  localparam int SR_IDX_LO   = 0;
  localparam int SR_IDX_HI   = 1;
  localparam int SR_SUB      = 2;
  localparam int SR_CMD      = 3;
  localparam int SR_STATUS   = 3;
  localparam int SR_NO       = 4;
  localparam int SR_NODE     = 5;
  localparam int SR_LEN      = 6;
  localparam int SR_DATA     = 7;
  localparam int SDO_DBYTES  = 4;
  localparam int SDO_REC_LEN = 11;
  localparam logic [7:0] SDO_OK   = 8'h00;
  localparam logic [7:0] SDO_BUSY = 8'h01;

  typedef enum logic [1:0] {
    SDO_IDLE = 2'b01,
    SDO_WAIT = 2'b10
  } cms_sdo_state_type;
endpackage : cms_pkg

// ---- hdl/cms_emcy_mem.sv ----
// Small register-file memory holding the queued emergency messages.
// Assumes one writer and one reader; read data is registered.
module cms_emcy_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = mem_ff[raddr];
  end

  // Storage has no reset; the queue pointers guard against stale entries.
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
    rdata_ff <= nxt_rdata;
  end

  assign rdata = rdata_ff;
endmodule : cms_emcy_mem

// ---- hdl/cms_node_supervisor.sv ----
// Node guarding, emergency queue, fieldbus control byte and SDO window.
// Assumes an AHB-Lite master, synchronous fieldbus byte strobes and a CAN engine.
// What this block does
// R1: No node is guarded after reset; each enabled node has id, interval and limit.
// R2: Each guarded node gets a guard request every interval in milliseconds.
// R3: A node fails only when consecutive missed answers reach its miss limit.
// R4: Liveness of eight nodes is packed into one status byte.
// R5: Lowest node sits in bit 0, highest node in bit 7.
// R6: Liveness is 1 only for an enabled node that answered in time.
// R7: The liveness byte appears at a configurable fieldbus output position.
// R8: Up to ten emergency messages are queued, only from guarded nodes.
// R9: Arrivals raise a pending counter; data, count and sender are shown.
// R10: The control byte acts only when mapped, at its configured input position.
// R11: Toggling bit 7 loads the next message and lowers a nonzero counter.
// R12: Any change of bit 6 sends a start command to make slaves operational.
// R13: A rising bit 5 requests all receive PDOs by remote frames.
// R14: The configuration maps between one and fifty receive PDOs for remote requests; the block has no PDO count setting, only one rtr_all pulse.
// R15: Control bits 4 to 0 are reserved and ignored.
// R16: The error byte appears at a configurable fieldbus output position.
// R17: Only the fieldbus master starts SDO; echoing the request number completes it.
// R18: The fieldbus master reserves room for the longest SDO record.
// R19: Response status is 0 for success, 1 for busy, else error.
// R20: Reply data beyond the request length is cut; otherwise true length returns.
// R21: Each request carries node, index, subindex, command, number and length.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
module cms_node_supervisor #(
  parameter int MS_TICKS = cms_pkg::MS_CYCLES
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic [cms_pkg::NODES-1:0] guard_ans,
  output logic      [cms_pkg::NODES-1:0] guard_req,
  input  wire logic                     emcy_valid,
  input  wire logic [7:0]               emcy_node,
  input  wire logic [63:0]              emcy_data,
  output logic                          nmt_start,
  output logic                          rtr_all,
  input  wire logic                     fb_in_we,
  input  wire logic [7:0]               fb_in_idx,
  input  wire logic [7:0]               fb_in_data,
  input  wire logic [7:0]               fb_out_idx,
  output logic      [7:0]               fb_out_data,
  output logic                          sdo_req,
  output logic      [7:0]               sdo_node,
  output logic      [15:0]              sdo_index,
  output logic      [7:0]               sdo_sub,
  output logic      [7:0]               sdo_cmd,
  output logic      [7:0]               sdo_len,
  output logic      [31:0]              sdo_wdata,
  input  wire logic                     sdo_done,
  input  wire logic [7:0]               sdo_done_status,
  input  wire logic [7:0]               sdo_done_len,
  input  wire logic [31:0]              sdo_done_data
);
  import cms_pkg::*;

  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic        ms_tick_ff, nxt_ms_tick;

  always_comb begin
    nxt_tick_cnt = tick_cnt_ff + 32'h1;
    nxt_ms_tick  = 1'b0;
    if (tick_cnt_ff == 32'(MS_TICKS - 1)) begin // [R2]
      nxt_tick_cnt = 32'h0;
      nxt_ms_tick  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_ff <= 32'h0;
      ms_tick_ff  <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      ms_tick_ff  <= nxt_ms_tick;
    end
  end

  logic [7:0]  guard_en_ff, nxt_guard_en;
  logic [31:0] pos_ff, nxt_pos;
  logic [31:0] map_ff, nxt_map;
  logic [31:0] node_cfg_ff [NODES];
  logic [31:0] nxt_node_cfg [NODES];
  logic        ovr_ff, nxt_ovr;
  logic        ap_wr_ff, nxt_ap_wr;
  logic        rd_pend_ff, nxt_rd_pend;
  logic [7:0]  ap_addr_ff, nxt_ap_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        ready_ff, nxt_ready;
  logic        take;
  logic        ovr_set;
  logic [7:0]  live_w, fail_w, err_byte;
  logic [3:0]  count_ff;
  logic [2:0]  cur_node_ff;
  logic [7:0]  request_window_offset, response_window_offset;

  assign request_window_offset  = map_ff[MAP_REQ_WIN +: 8];
  assign response_window_offset = map_ff[MAP_RSP_WIN +: 8];
  assign err_byte = {6'h00, ovr_ff, |fail_w};

  // Reads take one wait state so that a write in the preceding data phase is seen.
  always_comb begin
    take         = hsel & hready & htrans[1];
    nxt_ap_wr    = take & hwrite & (hsize == 3'h2);
    nxt_rd_pend  = take & ~hwrite;
    nxt_ap_addr  = take ? haddr[7:0] : ap_addr_ff;
    nxt_ready    = ~(take & ~hwrite);
    nxt_rdata    = rdata_ff;
    nxt_guard_en = guard_en_ff;
    nxt_pos      = pos_ff;
    nxt_map      = map_ff;
    nxt_node_cfg = node_cfg_ff;
    nxt_ovr      = ovr_ff;
    if (rd_pend_ff) begin
      case (ap_addr_ff)
        A_GUARD_EN: nxt_rdata = {24'h0, guard_en_ff};
        A_POS:      nxt_rdata = pos_ff;
        A_MAP:      nxt_rdata = map_ff;
        A_ERROR:    nxt_rdata = {24'h0, err_byte};
        A_STATUS:   nxt_rdata = {13'h0, cur_node_ff, 4'h0, count_ff, live_w};
        default:    nxt_rdata = (ap_addr_ff[7:5] == A_NODE_PAGE && ap_addr_ff[1:0] == 2'h0)
                                ? node_cfg_ff[ap_addr_ff[4:2]] : 32'h0;
      endcase
    end
    if (ap_wr_ff) begin
      case (ap_addr_ff)
        A_GUARD_EN: nxt_guard_en = hwdata[7:0]; // [R1]
        A_POS:      nxt_pos = hwdata; // [R7] [R16]
        A_MAP:      nxt_map = hwdata; // [R10]
        A_ERROR:    nxt_ovr = ovr_ff & ~hwdata[ERR_OVERRUN];
        default: begin
          if (ap_addr_ff[7:5] == A_NODE_PAGE && ap_addr_ff[1:0] == 2'h0) begin
            nxt_node_cfg[ap_addr_ff[4:2]] = hwdata; // [R1]
          end
        end
      endcase
    end
    // A new overrun wins over a clear in the same cycle.
    if (ovr_set) begin
      nxt_ovr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      guard_en_ff <= RST_GUARD_EN; // [R1]
      pos_ff      <= RST_POS;
      map_ff      <= RST_MAP;
      node_cfg_ff <= '{default: RST_NODE_CFG};
      ovr_ff      <= 1'b0;
      ap_wr_ff    <= 1'b0;
      rd_pend_ff  <= 1'b0;
      ap_addr_ff  <= 8'h00;
      rdata_ff    <= 32'h0;
      ready_ff    <= 1'b1;
    end else begin
      guard_en_ff <= nxt_guard_en;
      pos_ff      <= nxt_pos;
      map_ff      <= nxt_map;
      node_cfg_ff <= nxt_node_cfg;
      ovr_ff      <= nxt_ovr;
      ap_wr_ff    <= nxt_ap_wr;
      rd_pend_ff  <= nxt_rd_pend;
      ap_addr_ff  <= nxt_ap_addr;
      rdata_ff    <= nxt_rdata;
      ready_ff    <= nxt_ready;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp     = 1'b0;

  for (genvar i = 0; i < NODES; i++) begin : g_node
    logic [15:0] ms_cnt_ff, nxt_ms_cnt;
    logic [7:0]  miss_ff, nxt_miss;
    logic        wait_ff, nxt_wait, alive_ff, nxt_alive;
    logic        failed_ff, nxt_failed, req_ff, nxt_req;
    logic        missed;

    always_comb begin
      nxt_ms_cnt = ms_cnt_ff;
      nxt_miss   = miss_ff;
      nxt_wait   = wait_ff;
      nxt_alive  = alive_ff;
      nxt_failed = failed_ff;
      nxt_req    = 1'b0;
      missed     = wait_ff & ~guard_ans[i];
      if (!guard_en_ff[i]) begin // [R6]
        nxt_ms_cnt = 16'h0;
        nxt_miss   = 8'h00;
        nxt_wait   = 1'b0;
        nxt_alive  = 1'b0;
        nxt_failed = 1'b0;
      end else begin
        if (guard_ans[i] && wait_ff) begin // [R6]
          nxt_alive  = 1'b1;
          nxt_failed = 1'b0;
          nxt_miss   = 8'h00;
          nxt_wait   = 1'b0;
        end
        if (ms_tick_ff) begin
          if ({1'b0, ms_cnt_ff} + 17'h1 >= {1'b0, node_cfg_ff[i][CFG_IVAL +: 16]}) begin // [R2]
            nxt_ms_cnt = 16'h0;
            nxt_req    = 1'b1;
            nxt_wait   = 1'b1;
            if (missed) begin // [R3]
              nxt_miss = (miss_ff == 8'hff) ? miss_ff : miss_ff + 8'h1;
              if ({1'b0, miss_ff} + 9'h1 >= {1'b0, node_cfg_ff[i][CFG_LIMIT +: 8]}) begin
                nxt_alive  = 1'b0;
                nxt_failed = 1'b1;
              end
            end
          end else begin
            nxt_ms_cnt = ms_cnt_ff + 16'h1;
          end
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        ms_cnt_ff <= 16'h0;
        miss_ff   <= 8'h00;
        wait_ff   <= 1'b0;
        alive_ff  <= 1'b0;
        failed_ff <= 1'b0;
        req_ff    <= 1'b0;
      end else begin
        ms_cnt_ff <= nxt_ms_cnt;
        miss_ff   <= nxt_miss;
        wait_ff   <= nxt_wait;
        alive_ff  <= nxt_alive;
        failed_ff <= nxt_failed;
        req_ff    <= nxt_req;
      end
    end

    assign live_w[i]    = alive_ff; // [R4] [R5]
    assign fail_w[i]    = failed_ff;
    assign guard_req[i] = req_ff;
  end

  logic       ctrl_hit, pop;
  logic [2:0] ctl_prev_ff, nxt_ctl_prev;
  logic       nmt_ff, nxt_nmt, rtr_ff, nxt_rtr;

  // Only bits 7 to 5 are kept; the reserved low bits never reach any logic.
  always_comb begin
    ctrl_hit     = fb_in_we & map_ff[MAP_CTRL_EN] & (fb_in_idx == pos_ff[POS_CTRL +: 8]); // [R10]
    nxt_ctl_prev = ctl_prev_ff;
    nxt_nmt      = 1'b0;
    nxt_rtr      = 1'b0;
    pop          = 1'b0;
    if (ctrl_hit) begin
      nxt_ctl_prev = fb_in_data[CTL_EMCY:CTL_RTR]; // [R15]
      pop     = (fb_in_data[CTL_EMCY] != ctl_prev_ff[2]) && (count_ff != 4'h0); // [R11]
      nxt_nmt = fb_in_data[CTL_OP] != ctl_prev_ff[1]; // [R12]
      nxt_rtr = fb_in_data[CTL_RTR] & ~ctl_prev_ff[0]; // [R13]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_prev_ff <= 3'h0;
      nmt_ff      <= 1'b0;
      rtr_ff      <= 1'b0;
    end else begin
      ctl_prev_ff <= nxt_ctl_prev;
      nmt_ff      <= nxt_nmt;
      rtr_ff      <= nxt_rtr;
    end
  end

  assign nmt_start = nmt_ff;
  assign rtr_all   = rtr_ff;

  logic [3:0]        wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr, nxt_count;
  logic              load_ff, nxt_load, push, node_ok;
  logic [2:0]        emcy_idx, nxt_cur_node;
  logic [63:0]       cur_data_ff, nxt_cur_data;
  logic [EMCY_W-1:0] mem_rdata;

  always_comb begin
    emcy_idx     = 3'(emcy_node - 8'h1);
    node_ok      = (emcy_node != 8'h00) && (emcy_node <= 8'(NODES)) && guard_en_ff[emcy_idx]; // [R8]
    push         = emcy_valid & node_ok & (count_ff != 4'(EMCY_DEPTH));
    ovr_set      = emcy_valid & node_ok & (count_ff == 4'(EMCY_DEPTH));
    nxt_wr_ptr   = wr_ptr_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_count    = count_ff;
    nxt_load     = pop;
    nxt_cur_node = cur_node_ff;
    nxt_cur_data = cur_data_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == 4'(EMCY_DEPTH - 1)) ? 4'h0 : wr_ptr_ff + 4'h1;
    end
    if (pop) begin // [R11]
      nxt_rd_ptr = (rd_ptr_ff == 4'(EMCY_DEPTH - 1)) ? 4'h0 : rd_ptr_ff + 4'h1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 4'h1; // [R9]
    end else if (pop && !push) begin
      nxt_count = count_ff - 4'h1; // [R11]
    end
    if (load_ff) begin
      nxt_cur_node = mem_rdata[EMCY_W-1 -: 3];
      nxt_cur_data = mem_rdata[63:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_ff   <= 4'h0;
      rd_ptr_ff   <= 4'h0;
      count_ff    <= 4'h0;
      load_ff     <= 1'b0;
      cur_node_ff <= 3'h0;
      cur_data_ff <= 64'h0;
    end else begin
      wr_ptr_ff   <= nxt_wr_ptr;
      rd_ptr_ff   <= nxt_rd_ptr;
      count_ff    <= nxt_count;
      load_ff     <= nxt_load;
      cur_node_ff <= nxt_cur_node;
      cur_data_ff <= nxt_cur_data;
    end
  end

  cms_emcy_mem #(.WIDTH(EMCY_W), .DEPTH(EMCY_DEPTH), .AW(EMCY_PTR_W)) u_emcy_mem (
    .sys_clk (sys_clk),
    .we      (push),
    .waddr   (wr_ptr_ff),
    .wdata   ({emcy_idx, emcy_data}),
    .raddr   (rd_ptr_ff),
    .rdata   (mem_rdata)
  );

  cms_sdo_state_type sdo_st_ff, nxt_sdo_st;
  logic [7:0] req_ff [SDO_REC_LEN];
  logic [7:0] nxt_req [SDO_REC_LEN];
  logic [7:0] rsp_ff [SDO_REC_LEN];
  logic [7:0] nxt_rsp [SDO_REC_LEN];
  logic       sdo_req_ff, nxt_sdo_req;
  logic [7:0] req_off, cut_len;

  always_comb begin
    req_off     = fb_in_idx - request_window_offset;
    nxt_req     = req_ff;
    nxt_rsp     = rsp_ff;
    nxt_sdo_st  = sdo_st_ff;
    nxt_sdo_req = 1'b0;
    cut_len     = (sdo_done_len > req_ff[SR_LEN]) ? req_ff[SR_LEN] : sdo_done_len; // [R20]
    for (int k = 0; k < SDO_REC_LEN; k++) begin
      if (fb_in_we && req_off == 8'(k)) begin // [R21]
        nxt_req[k] = fb_in_data;
      end
    end
    case (sdo_st_ff)
      SDO_IDLE: begin
        if (req_ff[SR_NO] != rsp_ff[SR_NO]) begin // [R17]
          nxt_sdo_req        = 1'b1;
          nxt_rsp[SR_STATUS] = SDO_BUSY; // [R19]
          nxt_sdo_st         = SDO_WAIT;
        end
      end
      SDO_WAIT: begin
        if (sdo_done) begin
          for (int k = 0; k < SDO_REC_LEN; k++) begin
            nxt_rsp[k] = req_ff[k];
          end
          nxt_rsp[SR_STATUS] = sdo_done_status; // [R19]
          nxt_rsp[SR_LEN]    = cut_len; // [R20]
          for (int k = 0; k < SDO_DBYTES; k++) begin
            nxt_rsp[SR_DATA + k] = (8'(k) < cut_len) ? sdo_done_data[8*k +: 8] : 8'h00;
          end
          nxt_sdo_st = SDO_IDLE; // [R17]
        end
      end
      default: nxt_sdo_st = SDO_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdo_st_ff  <= SDO_IDLE;
      req_ff     <= '{default: 8'h00};
      rsp_ff     <= '{default: 8'h00};
      sdo_req_ff <= 1'b0;
    end else begin
      sdo_st_ff  <= nxt_sdo_st;
      req_ff     <= nxt_req;
      rsp_ff     <= nxt_rsp;
      sdo_req_ff <= nxt_sdo_req;
    end
  end

  assign sdo_req   = sdo_req_ff;
  assign sdo_node  = req_ff[SR_NODE];
  assign sdo_index = {req_ff[SR_IDX_HI], req_ff[SR_IDX_LO]};
  assign sdo_sub   = req_ff[SR_SUB];
  assign sdo_cmd   = req_ff[SR_CMD];
  assign sdo_len   = req_ff[SR_LEN];
  assign sdo_wdata = {req_ff[SR_DATA+3], req_ff[SR_DATA+2], req_ff[SR_DATA+1], req_ff[SR_DATA]};

  logic [7:0] fb_out_ff, nxt_fb_out, e_off, r_off;

  // Later matches override earlier ones when configured areas overlap.
  always_comb begin
    e_off      = fb_out_idx - pos_ff[POS_EMCY +: 8];
    r_off      = fb_out_idx - response_window_offset;
    nxt_fb_out = 8'h00;
    if (fb_out_idx == pos_ff[POS_LIVE +: 8]) begin
      nxt_fb_out = live_w; // [R7]
    end
    if (e_off == 8'h00) begin
      nxt_fb_out = {4'h0, count_ff}; // [R9]
    end else if (e_off == 8'h01) begin
      nxt_fb_out = 8'({cur_node_ff} + 4'h1);
    end else if (e_off < 8'(EMCY_REC_LEN)) begin
      nxt_fb_out = cur_data_ff[8*3'(e_off[2:0]-3'h2) +: 8];
    end
    if (fb_out_idx == pos_ff[POS_ERR +: 8]) begin
      nxt_fb_out = err_byte; // [R16]
    end
    for (int k = 0; k < SDO_REC_LEN; k++) begin
      if (r_off == 8'(k)) begin
        nxt_fb_out = rsp_ff[k]; // [R17]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fb_out_ff <= 8'h00;
    end else begin
      fb_out_ff <= nxt_fb_out;
    end
  end

  assign fb_out_data = fb_out_ff;

  property p_live_needs_en;
    @(posedge sys_clk) disable iff (rst) (live_w & ~$past(guard_en_ff)) == 8'h00;
  endproperty
  a_live_needs_en: assert property (p_live_needs_en) else $error("liveness set for a disabled node"); // [R6]
  property p_req_spacing;
    @(posedge sys_clk) disable iff (rst) guard_req[0] |=> !guard_req[0];
  endproperty
  a_req_spacing: assert property (p_req_spacing) else $error("guard requests back to back"); // [R2]
  property p_count_max;
    @(posedge sys_clk) disable iff (rst) count_ff <= 4'(EMCY_DEPTH);
  endproperty
  a_count_max: assert property (p_count_max) else $error("emergency count above depth"); // [R8]
  property p_reject;
    @(posedge sys_clk) disable iff (rst) (emcy_valid && !node_ok && !pop) |=> $stable(count_ff);
  endproperty
  a_reject: assert property (p_reject) else $error("message from unguarded node queued"); // [R8]
  property p_push_inc;
    @(posedge sys_clk) disable iff (rst) (push && !pop) |=> count_ff == $past(count_ff) + 4'h1;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("counter did not rise"); // [R9]
  property p_pop_dec;
    @(posedge sys_clk) disable iff (rst)
      (ctrl_hit && fb_in_data[7] != ctl_prev_ff[2] && !push) |=>
      count_ff == (($past(count_ff) == 4'h0) ? 4'h0 : $past(count_ff) - 4'h1);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("toggle did not lower counter"); // [R11]
  property p_nmt;
    @(posedge sys_clk) disable iff (rst) nmt_start |-> $past(ctrl_hit) && $past(fb_in_data[6]) != $past(ctl_prev_ff[1]);
  endproperty
  a_nmt: assert property (p_nmt) else $error("start command without bit 6 change"); // [R12]
  property p_rtr;
    @(posedge sys_clk) disable iff (rst) rtr_all |-> ctl_prev_ff[0] && !$past(ctl_prev_ff[0]);
  endproperty
  a_rtr: assert property (p_rtr) else $error("remote request without rising bit 5"); // [R13]
  property p_unmapped;
    @(posedge sys_clk) disable iff (rst) !map_ff[0] ##1 !map_ff[0] |-> !nmt_start && !rtr_all;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("control acted while unmapped"); // [R10]
  property p_sdo_busy;
    @(posedge sys_clk) disable iff (rst) sdo_req |-> sdo_st_ff == SDO_WAIT && rsp_ff[SR_STATUS] == SDO_BUSY;
  endproperty
  a_sdo_busy: assert property (p_sdo_busy) else $error("busy status missing"); // [R19]
  property p_sdo_echo;
    @(posedge sys_clk) disable iff (rst)
      (sdo_st_ff == SDO_WAIT && sdo_done) |=> rsp_ff[SR_NO] == $past(req_ff[SR_NO]) && rsp_ff[SR_LEN] <= sdo_len;
  endproperty
  a_sdo_echo: assert property (p_sdo_echo) else $error("bad echo or length"); // [R17] [R20]
  c_sdo: cover property (@(posedge sys_clk) disable iff (rst) sdo_req ##[1:50] sdo_st_ff == SDO_IDLE);
  c_pop: cover property (@(posedge sys_clk) disable iff (rst) load_ff && count_ff != 4'h0);
  c_live: cover property (@(posedge sys_clk) disable iff (rst) $rose(live_w[0]));
  c_nmt: cover property (@(posedge sys_clk) disable iff (rst) nmt_start);
endmodule : cms_node_supervisor

// ---- bench/cms_far_model.sv ----
// Far-side model: CAN slaves that answer guard requests, plus one SDO server.
// Assumes one-cycle request pulses from the supervision block on the same clock.
module cms_far_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  alive,
  input  wire logic [7:0]  guard_req,
  output logic      [7:0]  guard_ans,
  input  wire logic        sdo_req,
  output logic             sdo_done,
  output logic      [7:0]  sdo_done_status,
  output logic      [7:0]  sdo_done_len,
  output logic      [31:0] sdo_done_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] echo_ff;
  int         wait_ff;
  // The server is slow on purpose, so that the busy status stays visible.
  always_ff @(posedge sys_clk) begin
    echo_ff   <= rst ? 8'h00 : guard_req & alive;
    guard_ans <= rst ? 8'h00 : echo_ff;
    wait_ff   <= rst ? 0 : sdo_req ? 20 : wait_ff > 0 ? wait_ff - 1 : 0;
    sdo_done  <= !rst && wait_ff == 1;
  end
  // Outside the answer pulse the lines carry the inverse pattern.
  assign sdo_done_status = sdo_done ? 8'h00 : 8'hff;
  assign sdo_done_len    = sdo_done ? 8'h04 : 8'hfb;
  assign sdo_done_data   = sdo_done ? 32'h4443_4241 : 32'hbbbc_bdbe;
endmodule : cms_far_model

// ---- bench/tb_top.sv ----
// Self-checking bench for the node supervision block.
// Assumes cms_far_model plays the CAN slaves; the bench is the AHB and fieldbus master.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, emcy_valid, nmt_start, rtr_all;
  logic        fb_in_we, sdo_req, sdo_done;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  guard_ans, guard_req, emcy_node, fb_in_idx, fb_in_data, fb_out_idx, fb_out_data, sdo_st, sdo_ln;
  logic [31:0] haddr, hwdata, hrdata, sdo_dd, rd;
  logic [7:0]  sdo_nd;
  logic [15:0] sdo_ix;
  logic [63:0] emcy_data;
  logic [7:0]  req [7] = '{8'h09, 8'h10, 8'h00, 8'h01, 8'h00, 8'h05, 8'h02};
  int          mismatches = 0, n_checks = 0, n_nmt = 0, n_rtr = 0;
  cms_node_supervisor #(.MS_TICKS(10)) dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .guard_ans, .guard_req, .emcy_valid, .emcy_node,
    .emcy_data, .nmt_start, .rtr_all, .fb_in_we, .fb_in_idx, .fb_in_data, .fb_out_idx, .fb_out_data,
    .sdo_req, .sdo_node(sdo_nd), .sdo_index(sdo_ix), .sdo_sub(), .sdo_cmd(), .sdo_len(), .sdo_wdata(), .sdo_done,
    .sdo_done_status(sdo_st), .sdo_done_len(sdo_ln), .sdo_done_data(sdo_dd));
  cms_far_model far (.sys_clk, .rst, .alive(8'h01), .guard_req, .guard_ans, .sdo_req, .sdo_done,
    .sdo_done_status(sdo_st), .sdo_done_len(sdo_ln), .sdo_done_data(sdo_dd));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (nmt_start === 1'b1) n_nmt++;
    if (rtr_all === 1'b1) n_rtr++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic fbw(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    fb_in_we   <= 1'b1;
    fb_in_idx  <= i;
    fb_in_data <= d;
    @(posedge sys_clk);
    fb_in_we   <= 1'b0;
  endtask : fbw
  task automatic fbr(input logic [7:0] i, input logic [7:0] e);
    @(posedge sys_clk);
    fb_out_idx <= i;
    repeat (2) @(posedge sys_clk);
    #1 chk({24'h0, fb_out_data}, {24'h0, e});
  endtask : fbr
  task automatic emc(input logic [7:0] n);
    @(posedge sys_clk);
    emcy_valid <= 1'b1;
    emcy_node  <= n;
    @(posedge sys_clk);
    emcy_valid <= 1'b0;
  endtask : emc
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    #400000;
    mismatches++;
    results();
  end
  initial begin
    {hsel, hwrite, emcy_valid, fb_in_we, htrans, haddr, hwdata} = '0;
    {emcy_node, fb_in_idx, fb_in_data, fb_out_idx} = '0;
    emcy_data = 64'h0706_0504_0302_0100;
    hsize = 3'h2;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    ahb(0, A_GUARD_EN, 0);
    chk(rd, {24'h0, RST_GUARD_EN});
    ahb(0, A_POS, 0);
    chk(rd, RST_POS);
    ahb(0, A_MAP, 0);
    chk(rd, RST_MAP);
    ahb(0, 8'h20, 0);
    chk(rd, RST_NODE_CFG);
    ahb(0, 8'h18, 0);
    chk(rd, 32'h0);
    ahb(1, A_POS, 32'h2820_0200);
    ahb(1, 8'h20, 32'h0001_0001);
    ahb(1, 8'h24, 32'h0001_0001);
    emc(8'h01);
    repeat (60) @(posedge sys_clk);
    ahb(0, A_STATUS, 0);
    chk(rd & 32'hfff, 32'h0);
    ahb(1, A_GUARD_EN, 32'h3);
    emc(8'h03);
    repeat (100) @(posedge sys_clk);
    repeat (11) emc(8'h01);
    ahb(0, A_STATUS, 0);
    chk(rd & 32'hfff, 32'ha01);
    ahb(0, A_ERROR, 0);
    chk(rd & 32'h3, 32'h3);
    fbr(8'h02, 8'h01);
    fbr(8'h20, 8'h0a);
    fbr(8'h21, 8'h01);
    fbr(8'h28, 8'h03);
    fbw(8'h00, 8'h80);
    ahb(0, A_STATUS, 0);
    chk(rd & 32'hf00, 32'ha00);
    ahb(1, A_MAP, 32'h0008_0801);
    fbw(8'h00, 8'h80);
    fbw(8'h00, 8'h9f);
    fbw(8'h00, 8'hc0);
    fbw(8'h00, 8'he0);
    fbw(8'h00, 8'h80);
    ahb(0, A_STATUS, 0);
    chk(rd & 32'hf00, 32'h900);
    chk(n_nmt, 2);
    chk(n_rtr, 1);
    for (int k = 1; k < 11; k++) fbw(8'h00, {k[0], 7'h0});
    ahb(0, A_STATUS, 0);
    chk(rd & 32'hf00, 32'h000);
    foreach (req[k]) fbw(8'h08 + 8'(k), req[k]);
    fbw(8'h0c, 8'h01);
    fbr(8'h0b, 8'h01);
    chk({24'h0, sdo_nd}, 32'h5);
    chk({16'h0, sdo_ix}, 32'h1009);
    repeat (30) @(posedge sys_clk);
    fbr(8'h08, 8'h09);
    fbr(8'h0b, 8'h00);
    fbr(8'h0c, 8'h01);
    fbr(8'h0e, 8'h02);
    fbr(8'h0f, 8'h41);
    fbr(8'h11, 8'h00);
    results();
  end
endmodule : tb_top
